// [logic/sais_defs.svh]
// Purpose: Offsets, bit positions, reset values and timing counts for sync select
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Index times four gives the byte address
`ifndef SAIS_DEFS_SVH
`define SAIS_DEFS_SVH

// ****************************************
// Register indices and addresses
// ****************************************
`define SAIS_IDX_OUT_MODE 8'h10
`define SAIS_IDX_STATUS 8'h11
`define SAIS_IDX_SRC_SEL 8'h12
`define SAIS_ADDR_OUT_MODE 12'h040
`define SAIS_ADDR_STATUS 12'h044
`define SAIS_ADDR_SRC_SEL 12'h048

// ****************************************
// Field positions
// ****************************************
`define SAIS_BIT_DET_POL 2
`define SAIS_BIT_HS_DET 7
`define SAIS_BIT_GREEN_DET 6
`define SAIS_BIT_VS_DET 5
`define SAIS_BIT_CLK_DET 4
`define SAIS_BIT_IFACE_FLAG 3
`define SAIS_BIT_HS_FLAG 2
`define SAIS_BIT_VS_FLAG 1
`define SAIS_BIT_SEEK 0
`define SAIS_BIT_IFACE_OVR 7
`define SAIS_BIT_IFACE_SEL 6
`define SAIS_BIT_HSO 5
`define SAIS_BIT_HSS 4
`define SAIS_BIT_VSO 3
`define SAIS_BIT_VSS 2

// ****************************************
// Reset values and timing
// ****************************************
`define SAIS_RST_OUT_MODE 8'h00
`define SAIS_RST_SRC_SEL 8'h00
`define SAIS_TIMEOUT_US 100
`define SAIS_CLK_MHZ 100
`define SAIS_TIMEOUT_CYC (`SAIS_TIMEOUT_US * `SAIS_CLK_MHZ)

`endif

// [logic/sais_pkg.sv]
// Purpose: Type for the analog/digital interface select
// Assumes: Used with sais_defs.svh
// Notes: Types only
package sais_pkg;
  typedef enum logic [1:0] {
    SAIS_ANALOG = 2'b01,
    SAIS_DIGITAL = 2'b10
  } sais_iface_t;
endpackage

// [logic/sais_top.sv]
// Purpose: Sync activity detection and analog/digital source selection, APB slave
// Assumes: Sync inputs synchronous to pclk; link clock sampled as a level
// Notes: Activity timeout is a parameter so simulation can shorten it
`timescale 1ns/100ps
`include "sais_defs.svh"

module sais_top
  import sais_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `SAIS_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hsync_in,
  input wire logic green_sync_input,
  input wire logic vsync_in,
  input wire logic link_clk_in,
  input wire logic sep_vsync_in,
  output logic sync_active_pin,
  output logic active_interface_flag,
  output logic seek_mode,
  output logic hsync_route,
  output logic vsync_route
);

  // ****************************************
  // Activity detection
  // ****************************************
  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  logic [3:0] in_now;
  logic [3:0] in_q;
  logic [3:0] det_q;
  logic [CW-1:0] cnt_q [4];
  logic prime_q;

  assign in_now = {hsync_in, green_sync_input, vsync_in, link_clk_in};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_q <= 4'h0;
    end else begin
      in_q <= in_now;
    end
  end

  // Lines may rest high after reset; skip the first compare so no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prime_q <= 1'b0;
    end else begin
      prime_q <= 1'b1;
    end
  end

  // Any edge restarts the window; silence for the window clears the bit
  for (genvar i = 0; i < 4; i++) begin : g_det
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q[i] <= '0;
        det_q[i] <= 1'b0;
      end else if (prime_q && (in_now[i] != in_q[i])) begin
        cnt_q[i] <= '0;
        det_q[i] <= 1'b1;
      end else if (cnt_q[i] >= CW'(TIMEOUT_CYC - 1)) begin
        det_q[i] <= 1'b0;
      end else begin
        cnt_q[i] <= cnt_q[i] + CW'(1);
      end
    end
  end

  logic hs_det, green_det, vs_det, clk_det;
  assign hs_det = det_q[3];
  assign green_det = det_q[2];
  assign vs_det = det_q[1];
  assign clk_det = det_q[0];

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] mode_q;
  logic [7:0] sel_q;
  logic wr_en, rd_en;

  // Write lands only at the edge that ends the access
  assign wr_en = psel && penable && pready && pwrite && pstrb[0];
  assign rd_en = psel && penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `SAIS_RST_OUT_MODE;
      sel_q <= `SAIS_RST_SRC_SEL;
    end else if (wr_en) begin
      if (paddr == `SAIS_ADDR_OUT_MODE) begin
        mode_q <= pwdata[7:0];
      end
      if (paddr == `SAIS_ADDR_SRC_SEL) begin
        sel_q <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // Selection logic
  // ****************************************
  logic ana_det;
  logic iface_d, seek_d, hs_pick_d, vs_pick_d;
  sais_iface_t iface;

  assign ana_det = hs_det | green_det | vs_det;

  always_comb begin
    seek_d = 1'b0;
    if (sel_q[`SAIS_BIT_IFACE_OVR]) begin
      iface_d = sel_q[`SAIS_BIT_IFACE_SEL];
    end else if (ana_det && clk_det) begin
      iface_d = sel_q[`SAIS_BIT_IFACE_SEL];
    end else if (clk_det) begin
      iface_d = 1'b1;
    end else if (ana_det) begin
      iface_d = 1'b0;
    end else begin
      // Flag keeps analog while seeking
      iface_d = 1'b0;
      seek_d = 1'b1;
    end
    if (sel_q[`SAIS_BIT_HSO] || (hs_det == green_det)) begin
      hs_pick_d = sel_q[`SAIS_BIT_HSS];
    end else begin
      hs_pick_d = green_det;
    end
    if (sel_q[`SAIS_BIT_VSO]) begin
      vs_pick_d = sel_q[`SAIS_BIT_VSS];
    end else begin
      vs_pick_d = vs_det;
    end
  end

  assign iface = iface_d ? SAIS_DIGITAL : SAIS_ANALOG;

  logic hs_pick_q, vs_pick_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_interface_flag <= 1'b0;
      seek_mode <= 1'b0;
      hs_pick_q <= 1'b0;
      vs_pick_q <= 1'b0;
    end else begin
      active_interface_flag <= (iface == SAIS_DIGITAL);
      seek_mode <= seek_d;
      hs_pick_q <= hs_pick_d;
      vs_pick_q <= vs_pick_d;
    end
  end

  // ****************************************
  // Routing and activity pin
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsync_route <= 1'b0;
      vsync_route <= 1'b0;
      sync_active_pin <= 1'b0;
    end else begin
      // Hsync or green sync
      // Live choice, so a select write shows on the next clock
      hsync_route <= hs_pick_d ? green_sync_input : hsync_in;
      vsync_route <= vs_pick_d ? sep_vsync_in : vsync_in;
      sync_active_pin <= (ana_det | clk_det) ^ mode_q[`SAIS_BIT_DET_POL];
    end
  end

  // ****************************************
  // APB read path
  // ****************************************
  logic [7:0] status;
  assign status = {hs_det, green_det, vs_det, clk_det,
                   active_interface_flag, hs_pick_q, vs_pick_q, seek_mode};

  // One wait state; reads have no side effects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !(paddr == `SAIS_ADDR_OUT_MODE || paddr == `SAIS_ADDR_STATUS ||
                   paddr == `SAIS_ADDR_SRC_SEL);
      if (!rd_en) begin
        prdata <= 32'h0;
      end else if (paddr == `SAIS_ADDR_OUT_MODE) begin
        prdata <= {24'h0, mode_q};
      end else if (paddr == `SAIS_ADDR_STATUS) begin
        prdata <= {24'h0, status};
      end else if (paddr == `SAIS_ADDR_SRC_SEL) begin
        prdata <= {24'h0, sel_q};
      end else begin
        prdata <= 32'h0;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************
  // Checker helpers
  // ****************************************
  // Own quiet counters, so idle checks do not lean on the detector state
  localparam int QW = CW + 1;
  logic [3:0] chk_prev_q;
  logic [QW-1:0] chk_quiet_q [4];

  for (genvar k = 0; k < 4; k++) begin : g_quiet
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chk_prev_q[k] <= 1'b0;
        chk_quiet_q[k] <= '0;
      end else begin
        chk_prev_q[k] <= in_now[k];
        if (in_now[k] != chk_prev_q[k]) begin
          chk_quiet_q[k] <= '0;
        end else if (chk_quiet_q[k] < QW'(TIMEOUT_CYC)) begin
          chk_quiet_q[k] <= chk_quiet_q[k] + QW'(1);
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Activity pin and detectors
  pin_polarity_a: assert property (
    sync_active_pin == $past((ana_det | clk_det) ^ mode_q[`SAIS_BIT_DET_POL]))
    else $error("activity pin level wrong");
  hs_edge_a: assert property (
    (prime_q && hsync_in != $past(hsync_in)) |=> hs_det)
    else $error("hsync edge missed");
  hs_idle_a: assert property (
    (chk_quiet_q[3] == QW'(TIMEOUT_CYC)) |-> !hs_det)
    else $error("held hsync still active");
  edge_sets_a: assert property (
    (prime_q && green_sync_input != $past(green_sync_input)) |=> green_det)
    else $error("green sync edge missed");
  green_idle_a: assert property (
    (chk_quiet_q[2] == QW'(TIMEOUT_CYC)) |-> !green_det)
    else $error("held green sync still active");
  vs_edge_a: assert property (
    (prime_q && vsync_in != $past(vsync_in)) |=> vs_det)
    else $error("vsync edge missed");
  vs_idle_a: assert property (
    (chk_quiet_q[1] == QW'(TIMEOUT_CYC)) |-> !vs_det)
    else $error("held vsync still active");
  clk_edge_a: assert property (
    (prime_q && link_clk_in != $past(link_clk_in)) |=> clk_det)
    else $error("link clock edge missed");
  clk_idle_a: assert property (
    (chk_quiet_q[0] == QW'(TIMEOUT_CYC)) |-> !clk_det)
    else $error("stopped link clock still active");

  // Interface choice
  override_ai_a: assert property (
    sel_q[`SAIS_BIT_IFACE_OVR] |=>
    active_interface_flag == $past(sel_q[`SAIS_BIT_IFACE_SEL]))
    else $error("interface override ignored");
  tie_ai_a: assert property (
    (!sel_q[`SAIS_BIT_IFACE_OVR] && ana_det && clk_det) |=>
    active_interface_flag == $past(sel_q[`SAIS_BIT_IFACE_SEL]))
    else $error("interface tie not from select");
  auto_ai_a: assert property (
    (!sel_q[`SAIS_BIT_IFACE_OVR] && clk_det && !ana_det) |=> active_interface_flag)
    else $error("digital only not chosen");
  analog_only_a: assert property (
    (!sel_q[`SAIS_BIT_IFACE_OVR] && ana_det && !clk_det) |=> !active_interface_flag)
    else $error("analog only not chosen");
  seek_mode_a: assert property (
    (!sel_q[`SAIS_BIT_IFACE_OVR] && !clk_det && !ana_det) |=> seek_mode)
    else $error("seek mode not entered");
  seek_clear_a: assert property (
    (sel_q[`SAIS_BIT_IFACE_OVR] || ana_det || clk_det) |=> !seek_mode)
    else $error("seek mode without cause");

  // Sync choice
  hs_pick_a: assert property (
    (!sel_q[`SAIS_BIT_HSO] && hs_det && !green_det) |=> !hs_pick_q)
    else $error("hsync auto choice wrong");
  green_pick_a: assert property (
    (!sel_q[`SAIS_BIT_HSO] && !hs_det && green_det) |=> hs_pick_q)
    else $error("green sync auto choice wrong");
  hs_ovr_a: assert property (
    sel_q[`SAIS_BIT_HSO] |=> hs_pick_q == $past(sel_q[`SAIS_BIT_HSS]))
    else $error("hsync override ignored");
  vs_pick_a: assert property (
    !sel_q[`SAIS_BIT_VSO] |=> vs_pick_q == $past(vs_det))
    else $error("vsync auto choice wrong");
  vs_ovr_a: assert property (
    sel_q[`SAIS_BIT_VSO] |=> vs_pick_q == $past(sel_q[`SAIS_BIT_VSS]))
    else $error("vsync override ignored");

  // Register bus
  write_lands_a: assert property (
    (psel && penable && pready && pwrite && pstrb[0] && paddr == `SAIS_ADDR_SRC_SEL)
    |=> sel_q == $past(pwdata[7:0]))
    else $error("select write lost");
  apb_ready_a: assert property (
    (psel && !penable) ##1 (psel && penable) |=> pready)
    else $error("apb answer late");
  ready_pulse_a: assert property (
    pready |=> !pready)
    else $error("apb ready held too long");
  err_with_ready_a: assert property (
    pslverr |-> pready)
    else $error("apb error without ready");
  mapped_ok_a: assert property (
    (psel && penable && !pready && paddr == `SAIS_ADDR_STATUS) |=> !pslverr)
    else $error("apb error on mapped register");

  // ****************************************
  // Cover points
  // ****************************************
  both_det_c: cover property (ana_det && clk_det);
  seek_c: cover property (seek_mode);
  override_c: cover property (sel_q[`SAIS_BIT_IFACE_OVR] && active_interface_flag);
  timeout_c: cover property (hs_det ##1 !hs_det);
  green_pick_c: cover property (!hs_det && green_det && hs_pick_q);

endmodule

// [testbench/sais_src_model.sv]
// Purpose: Graphics source model driving the sync and link clock lines
// Assumes: Lines change just after a rising pclk edge
// Notes: A stopped line holds its last level, as a stuck sync would
`timescale 1ns/100ps

module sais_src_model (
  input wire logic pclk,
  input wire logic [3:0] run,
  output logic hsync_in,
  output logic green_sync_input,
  output logic vsync_in,
  output logic link_clk_in,
  output logic sep_vsync_in
);
  logic [7:0] cnt_q;

  initial begin
    cnt_q = 8'h00;
    hsync_in = 1'b1;
    green_sync_input = 1'b0;
    vsync_in = 1'b1;
    link_clk_in = 1'b0;
    sep_vsync_in = 1'b0;
  end

  // Different rates on the four run lines, sep_vsync_in same rate as vsync but a cycle later, so a wrong route shows up
  always @(posedge pclk) begin
    cnt_q <= cnt_q + 8'h01;
    if (run[0] && cnt_q[0]) hsync_in <= !hsync_in;
    if (run[1] && (cnt_q % 3 == 0)) green_sync_input <= !green_sync_input;
    if (run[2] && cnt_q[1:0] == 2'b11) vsync_in <= !vsync_in;
    if (run[3]) link_clk_in <= !link_clk_in;
    sep_vsync_in <= cnt_q[2];
  end
endmodule

// [testbench/tb_top.sv]
// Purpose: Register and selection checks for the sync select block
// Assumes: Activity timeout shortened to 20 cycles
// Notes: Expected status is worked out from the selection tables
`timescale 1ns/100ps
`include "sais_defs.svh"

module tb_top;
  import sais_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, run;
  logic hsync_in, green_sync_input, vsync_in, link_clk_in, sep_vsync_in;
  logic sync_active_pin, active_interface_flag, seek_mode, hsync_route, vsync_route;
  logic [7:0] e;
  logic [7:0] sels [7] = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'h34, 8'h1c, 8'h28};
  int n_fail, compares;

  sais_top #(.TIMEOUT_CYC(20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hsync_in(hsync_in),
    .green_sync_input(green_sync_input), .vsync_in(vsync_in), .link_clk_in(link_clk_in),
    .sep_vsync_in(sep_vsync_in), .sync_active_pin(sync_active_pin),
    .active_interface_flag(active_interface_flag), .seek_mode(seek_mode),
    .hsync_route(hsync_route), .vsync_route(vsync_route));

  sais_src_model u_src (.pclk(pclk), .run(run), .hsync_in(hsync_in),
    .green_sync_input(green_sync_input), .vsync_in(vsync_in),
    .link_clk_in(link_clk_in), .sep_vsync_in(sep_vsync_in));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run;
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request stands until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] exp_status(input logic [3:0] r, input logic [7:0] s);
    logic an, iface, hs_pick, vs_pick, seek;
    an = |r[2:0];
    seek = !s[7] && !an && !r[3];
    iface = s[7] ? s[6] : ((an && r[3]) ? s[6] : r[3]);
    hs_pick = s[5] ? s[4] : ((r[0] != r[1]) ? r[1] : s[4]);
    vs_pick = s[3] ? s[2] : r[2];
    return {r[0], r[1], r[2], r[3], iface, hs_pick, vs_pick, seek};
  endfunction

  task automatic chk_route(input logic hs_sel, input logic vs_sel);
    logic h, v;
    @(negedge pclk);
    h = hs_sel ? green_sync_input : hsync_in;
    v = vs_sel ? sep_vsync_in : vsync_in;
    @(negedge pclk);
    chk("hsync_route", {31'h0, h}, {31'h0, hsync_route});
    chk("vsync_route", {31'h0, v}, {31'h0, vsync_route});
  endtask

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = !pclk;
  end

  initial begin
    #200000;
    n_fail++;
    complete_run;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    run = 4'h0;
    n_fail = 0;
    compares = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SAIS_ADDR_OUT_MODE, 32'h0);
    chk("mode reset", 32'h0, rd);
    apb(1'b0, `SAIS_ADDR_SRC_SEL, 32'h0);
    chk("select reset", 32'h0, rd);
    apb(1'b0, `SAIS_ADDR_STATUS, 32'h0);
    chk("idle status", 32'h1, rd);
    chk("idle seek", 32'h1, {31'h0, seek_mode});
    chk("idle pin", 32'h0, {31'h0, sync_active_pin});
    apb(1'b0, 12'h04c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, `SAIS_ADDR_STATUS, 32'hff);
    apb(1'b0, `SAIS_ADDR_STATUS, 32'h0);
    chk("status ro", 32'h1, rd);
    pstrb <= 4'he;
    apb(1'b1, `SAIS_ADDR_SRC_SEL, 32'hff);
    pstrb <= 4'hf;
    apb(1'b0, `SAIS_ADDR_SRC_SEL, 32'h0);
    chk("strobe off", 32'h0, rd);
    apb(1'b1, `SAIS_ADDR_OUT_MODE, 32'h4);
    apb(1'b0, `SAIS_ADDR_OUT_MODE, 32'h0);
    chk("mode rw", 32'h4, rd);
    chk("inverted pin", 32'h1, {31'h0, sync_active_pin});
    apb(1'b1, `SAIS_ADDR_OUT_MODE, 32'h0);
    for (int r = 0; r < 16; r++) begin
      run <= r[3:0];
      // Long enough for stopped lines to time out
      repeat (30) @(posedge pclk);
      chk("pin", {31'h0, |r[3:0]}, {31'h0, sync_active_pin});
      foreach (sels[i]) begin
        apb(1'b1, `SAIS_ADDR_SRC_SEL, {24'h0, sels[i]});
        apb(1'b0, `SAIS_ADDR_STATUS, 32'h0);
        e = exp_status(r[3:0], sels[i]);
        chk("status", {24'h0, e}, rd);
        chk("iface", {31'h0, e[3]}, {31'h0, active_interface_flag});
        chk("seek", {31'h0, e[0]}, {31'h0, seek_mode});
        chk_route(e[2], e[1]);
      end
    end
    complete_run;
  end
endmodule
